// ### verilog/acmp_pkg.sv
/*
  Constants for the comparator control block: I/O offsets, bit positions,
  reset values and event mode codes.
  Assumes the CPU reaches registers by 6-bit I/O offset, one byte wide.
*/
`default_nettype none
package acmp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL_STATUS = 6'h08;
  localparam logic [5:0] OFF_SPECIAL_IO  = 6'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DISABLE     = 7;
  localparam int BIT_BANDGAP     = 6;
  localparam int BIT_OUT_SYNC    = 5;
  localparam int BIT_IRQ_FLAG    = 4;
  localparam int BIT_IRQ_ENABLE  = 3;
  localparam int BIT_CAPTURE     = 2;
  localparam int BIT_MODE_HI     = 1;
  localparam int BIT_MODE_LO     = 0;
  localparam int BIT_NEG_MUX_EN  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic       RST_NEG_MUX = 1'b0;

  // ----------------------------------------------------------------
  // Event modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALL     = 2'h2,
    MODE_RISE     = 2'h3
  } irq_mode_e;
endpackage : acmp_pkg
`default_nettype wire

// ### verilog/acmp_evt_if.sv
/*
  Carrier between the control block and its edge detector.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface acmp_evt_if;
  logic               sync_level;
  acmp_pkg::irq_mode_e mode;
  logic               event_hit;
  modport ctrl (output sync_level, output mode, input event_hit);
  modport det  (input sync_level, input mode, output event_hit);
endinterface : acmp_evt_if
`default_nettype wire

// ### verilog/acmp_edge_det.sv
/*
  Edge detector: compares the synchronised comparator level with its
  value one cycle earlier and reports the event chosen by the mode.
  Assumes the level is already synchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module acmp_edge_det (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  acmp_evt_if.det     evt
);
  logic prev_q;
  logic prev_d;
  logic hit;

  always_comb
  begin
    prev_d = evt.sync_level;
    hit    = 1'b0;
    unique case (evt.mode)
      acmp_pkg::MODE_TOGGLE:   hit = evt.sync_level ^ prev_q;
      acmp_pkg::MODE_FALL:     hit = prev_q & ~evt.sync_level;
      acmp_pkg::MODE_RISE:     hit = ~prev_q & evt.sync_level;
      acmp_pkg::MODE_RESERVED: hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d;
  end

  assign evt.event_hit = hit;

  property p_rise_hit;
    @(posedge sys_clk) disable iff (rst)
      (evt.mode == acmp_pkg::MODE_RISE && $rose(evt.sync_level)) |-> hit;
  endproperty
  a_rise_hit: assert property (p_rise_hit)
    else $error("Rising edge missed.");

  property p_reserved_quiet;
    @(posedge sys_clk) disable iff (rst)
      (evt.mode == acmp_pkg::MODE_RESERVED) |-> !hit;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("Reserved mode raised an event.");
endmodule : acmp_edge_det
`default_nettype wire

// ### verilog/acmp_ctrl.sv
/*
  Digital control around an analog comparator: input selection,
  output synchroniser, event flag, interrupt request and capture routing.
  Assumes a byte-wide I/O port from the CPU with single-cycle strobes,
  and that the comparator output is asynchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Mux enable set and converter off routes selected channel pin to negative input.
// - Otherwise the dedicated negative pin drives the negative input.
// - Writing the disable bit one powers the comparator off.
// - Bandgap select feeds reference to positive input, else positive pin.
// - Comparator result is synchronised, one to two cycles latency.
// - Flag sets on the event chosen by the mode field.
// - Request only while flag, enable and global enable are all set.
// - Flag clears when the processor executes the vector.
// - Writing one to the flag clears it; zero leaves it.
// - Mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Capture enable routes comparator output to the timer capture front end.
// - With capture enable clear there is no capture connection.
module acmp_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [5:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  output logic      [7:0] io_rdata,
  input  wire logic       converter_enable,
  input  wire logic [2:0] channel_select,
  input  wire logic       global_irq_enable,
  input  wire logic       irq_ack,
  input  wire logic       comparator_raw,
  output logic            irq_req,
  output logic            capture_out,
  output logic            comparator_disable,
  output logic            bandgap_select,
  output logic            neg_use_channel,
  output logic      [2:0] neg_channel
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       sync1_q,  sync1_d;
  logic       sync2_q,  sync2_d;
  logic       dis_q,    dis_d;
  logic       bg_q,     bg_d;
  logic       flag_q,   flag_d;
  logic       ien_q,    ien_d;
  logic       cap_en_q, cap_en_d;
  logic [1:0] mode_q,   mode_d;
  logic       nme_q,    nme_d;
  logic       irq_q,    irq_d;
  logic       capo_q,   capo_d;
  logic       nuse_q,   nuse_d;
  logic [2:0] nch_q,    nch_d;
  logic [7:0] rdata_q,  rdata_d;
  logic       wr_ctrl;
  logic       wr_sfio;
  logic       hit;

  acmp_evt_if evt ();

  assign evt.sync_level = sync2_q;
  assign evt.mode       = acmp_pkg::irq_mode_e'(mode_q);
  assign hit            = evt.event_hit;

  acmp_edge_det u_det (
    .sys_clk (sys_clk),
    .rst     (rst),
    .evt     (evt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Output bits are registered copies, so pins lag their cause by one cycle.
  always_comb
  begin
    wr_ctrl  = io_wr && io_addr == acmp_pkg::OFF_CTRL_STATUS;
    wr_sfio  = io_wr && io_addr == acmp_pkg::OFF_SPECIAL_IO;
    sync1_d  = comparator_raw;
    sync2_d  = sync1_q;
    dis_d    = wr_ctrl ? io_wdata[acmp_pkg::BIT_DISABLE] : dis_q;
    bg_d     = wr_ctrl ? io_wdata[acmp_pkg::BIT_BANDGAP] : bg_q;
    ien_d    = wr_ctrl ? io_wdata[acmp_pkg::BIT_IRQ_ENABLE] : ien_q;
    cap_en_d = wr_ctrl ? io_wdata[acmp_pkg::BIT_CAPTURE] : cap_en_q;
    mode_d   = wr_ctrl ? io_wdata[acmp_pkg::BIT_MODE_HI:acmp_pkg::BIT_MODE_LO]
                       : mode_q;
    nme_d    = wr_sfio ? io_wdata[acmp_pkg::BIT_NEG_MUX_EN] : nme_q;
    // A new event wins over a clear in the same cycle.
    flag_d   = flag_q;
    if (irq_ack)
      flag_d = 1'b0;
    if (wr_ctrl && io_wdata[acmp_pkg::BIT_IRQ_FLAG])
      flag_d = 1'b0;
    if (hit)
      flag_d = 1'b1;
    irq_d    = flag_d && ien_d && global_irq_enable;
    capo_d   = cap_en_d ? sync2_q : 1'b0;
    nuse_d   = nme_d && !converter_enable;
    nch_d    = nuse_d ? channel_select : 3'h0;
    rdata_d  = 8'h00;
    if (io_rd && io_addr == acmp_pkg::OFF_CTRL_STATUS)
      rdata_d = {dis_q, bg_q, sync2_q, flag_q, ien_q, cap_en_q, mode_q};
    else if (io_rd && io_addr == acmp_pkg::OFF_SPECIAL_IO)
      rdata_d = {4'h0, nme_q, 3'h0};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      dis_q    <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_DISABLE];
      bg_q     <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_BANDGAP];
      flag_q   <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_IRQ_FLAG];
      ien_q    <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_IRQ_ENABLE];
      cap_en_q <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_CAPTURE];
      mode_q   <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_MODE_HI:acmp_pkg::BIT_MODE_LO];
      nme_q    <= acmp_pkg::RST_NEG_MUX;
      irq_q    <= 1'b0;
      capo_q   <= 1'b0;
      nuse_q   <= 1'b0;
      nch_q    <= 3'h0;
      rdata_q  <= 8'h00;
    end
    else
    begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      dis_q    <= dis_d;
      bg_q     <= bg_d;
      flag_q   <= flag_d;
      ien_q    <= ien_d;
      cap_en_q <= cap_en_d;
      mode_q   <= mode_d;
      nme_q    <= nme_d;
      irq_q    <= irq_d;
      capo_q   <= capo_d;
      nuse_q   <= nuse_d;
      nch_q    <= nch_d;
      rdata_q  <= rdata_d;
    end
  end

  assign io_rdata           = rdata_q;
  assign irq_req            = irq_q;
  assign capture_out        = capo_q;
  assign comparator_disable = dis_q;
  assign bandgap_select     = bg_q;
  assign neg_use_channel    = nuse_q;
  assign neg_channel        = nch_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_clear_write;
    wr_ctrl && io_wdata[acmp_pkg::BIT_IRQ_FLAG] && !hit;
  endsequence

  property p_flag_clear;
    @(posedge sys_clk) disable iff (rst)
      s_clear_write |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Flag not cleared by write of one.");

  property p_flag_set;
    @(posedge sys_clk) disable iff (rst) hit |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Event did not set flag.");

  property p_ack_clear;
    @(posedge sys_clk) disable iff (rst) (irq_ack && !hit) |=> !flag_q;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("Vector did not clear flag.");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (rst)
      irq_req |-> (flag_q && ien_q && $past(global_irq_enable));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Request without flag and enables.");

  property p_sync_delay;
    @(posedge sys_clk) disable iff (rst)
      $rose(comparator_raw) ##2 $stable(comparator_raw) |-> sync2_q;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Synchronised output late.");

  property p_capture_off;
    @(posedge sys_clk) disable iff (rst)
      $past(!cap_en_d) |-> !capture_out;
  endproperty
  a_capture_off: assert property (p_capture_off)
    else $error("Capture driven while routing off.");

  property p_capture_on;
    @(posedge sys_clk) disable iff (rst)
      $past(cap_en_d) |-> capture_out == $past(sync2_q);
  endproperty
  a_capture_on: assert property (p_capture_on)
    else $error("Capture does not follow output.");

  property p_neg_select;
    @(posedge sys_clk) disable iff (rst)
      neg_use_channel |-> ($past(nme_d) && !$past(converter_enable)
                          && neg_channel == $past(channel_select));
  endproperty
  a_neg_select: assert property (p_neg_select)
    else $error("Channel route without its conditions.");

  property p_neg_pin;
    @(posedge sys_clk) disable iff (rst)
      $past(converter_enable) |-> !neg_use_channel;
  endproperty
  a_neg_pin: assert property (p_neg_pin)
    else $error("Channel route while converter on.");

  property p_irq_raise;
    @(posedge sys_clk) disable iff (rst)
      (flag_q && ien_q && $past(global_irq_enable)) |-> irq_req;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("Request missing with flag and enables set.");

  sequence s_no_flag_cause;
    !hit && !irq_ack && !(wr_ctrl && io_wdata[acmp_pkg::BIT_IRQ_FLAG]);
  endsequence

  property p_flag_hold;
    @(posedge sys_clk) disable iff (rst)
      s_no_flag_cause |=> flag_q == $past(flag_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Flag changed without an event, clear or vector.");

  property p_sync_fall;
    @(posedge sys_clk) disable iff (rst)
      $fell(comparator_raw) ##2 $stable(comparator_raw) |-> !sync2_q;
  endproperty
  a_sync_fall: assert property (p_sync_fall)
    else $error("Synchronised output late to fall.");

  property p_toggle_flag;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == acmp_pkg::MODE_TOGGLE && $changed(sync2_q)) |=> flag_q;
  endproperty
  a_toggle_flag: assert property (p_toggle_flag)
    else $error("Output toggle did not set flag.");

  property p_fall_flag;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == acmp_pkg::MODE_FALL && $fell(sync2_q)) |=> flag_q;
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("Falling output did not set flag.");

  property p_reserved_flag;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == acmp_pkg::MODE_RESERVED && !flag_q) |=> !flag_q;
  endproperty
  a_reserved_flag: assert property (p_reserved_flag)
    else $error("Reserved mode set the flag.");

  property p_disable_wr;
    @(posedge sys_clk) disable iff (rst)
      wr_ctrl |=>
        comparator_disable == $past(io_wdata[acmp_pkg::BIT_DISABLE]);
  endproperty
  a_disable_wr: assert property (p_disable_wr)
    else $error("Disable output does not follow the write.");

  property p_bandgap_wr;
    @(posedge sys_clk) disable iff (rst)
      wr_ctrl |=>
        bandgap_select == $past(io_wdata[acmp_pkg::BIT_BANDGAP]);
  endproperty
  a_bandgap_wr: assert property (p_bandgap_wr)
    else $error("Bandgap output does not follow the write.");

  property p_neg_off;
    @(posedge sys_clk) disable iff (rst)
      !$past(nme_d) |-> !neg_use_channel;
  endproperty
  a_neg_off: assert property (p_neg_off)
    else $error("Channel route while mux enable clear.");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (rst)
      !$past(io_rd) |-> io_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not zero outside a read.");
endmodule : acmp_ctrl
`default_nettype wire

// ### bench/acmp_ack_model.sv
/*
  Model of the CPU side that services the comparator interrupt vector.
  Assumes irq_req is a level from the block under test on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module acmp_ack_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  input  wire logic [3:0] ack_delay,
  output logic            irq_ack
);
  // ----------------------------------------------------------------
  // Vector entry after a programmable latency
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  logic       busy_q;

  // A long delay shows how an interrupt latency stretches the request.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !irq_req)
    begin
      cnt_q   <= 4'h0;
      busy_q  <= 1'b0;
      irq_ack <= 1'b0;
    end
    else if (!busy_q && cnt_q == ack_delay)
    begin
      irq_ack <= 1'b1;
      busy_q  <= 1'b1;
    end
    else
    begin
      irq_ack <= 1'b0;
      if (!busy_q)
        cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : acmp_ack_model
`default_nettype wire

// ### bench/tb_top.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the design files and the acknowledge model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        sys_clk;
  logic        rst;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_rdata;
  logic        converter_enable;
  logic [2:0]  channel_select;
  logic        global_irq_enable;
  logic        irq_ack;
  logic        comparator_raw;
  logic        irq_req;
  logic        capture_out;
  logic        comparator_disable;
  logic        bandgap_select;
  logic        neg_use_channel;
  logic [2:0]  neg_channel;
  logic [3:0]  ack_delay;
  logic [7:0]  rd_v;
  logic [31:0] seed;
  int          n_mismatch;
  int          n_compared;
  int          old;
  int          flg;

  acmp_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .converter_enable(converter_enable), .channel_select(channel_select),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
    .comparator_raw(comparator_raw), .irq_req(irq_req),
    .capture_out(capture_out), .comparator_disable(comparator_disable),
    .bandgap_select(bandgap_select), .neg_use_channel(neg_use_channel),
    .neg_channel(neg_channel));
  acmp_ack_model ack_u (.sys_clk(sys_clk), .rst(rst), .irq_req(irq_req),
    .ack_delay(ack_delay), .irq_ack(irq_ack));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask : chk

  // Inputs move 1 ns after the edge so no race with the design's flops.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(2);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    io_addr = a;
    io_rd   = 1'b1;
    tick(1);
    io_rd = 1'b0;
    rd_v  = io_rdata;
    tick(1);
  endtask : rd

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // Reference event decode on the previous and current level.
  function automatic int evt(input int md, input int a, input int b);
    return (md == 0 && a != b) || (md == 2 && a == 1 && b == 0) ||
           (md == 3 && a == 0 && b == 1);
  endfunction : evt

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    {io_addr, io_wdata, io_wr, io_rd} = 16'h0000;
    {converter_enable, channel_select, global_irq_enable} = 5'h00;
    comparator_raw = 1'b0;
    ack_delay = 4'h6;
    seed = 32'h3c540a1c;
    n_mismatch = 0;
    n_compared = 0;
    tick(4);
    rst = 1'b0;
    rd(6'h08);
    chk("ctrl_reset", rd_v, 8'h00);
    rd(6'h30);
    chk("special_reset", rd_v, 8'h00);
    rd(6'h15);
    chk("unmapped", rd_v, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      converter_enable = seed[8];
      channel_select = seed[11:9];
      wr(6'h30, seed[7:0]);
      chk("neg_use", neg_use_channel, seed[3] & ~seed[8]);
      chk("neg_chan", neg_channel, {3{seed[3] & ~seed[8]}} & seed[11:9]);
      rd(6'h30);
      chk("special_rd", rd_v, {4'h0, seed[3], 3'h0});
    end
    // Enable stays clear while the mode changes, as software must.
    for (int md = 0; md < 4; md++)
    begin
      wr(6'h08, {6'h04, md[1:0]});
      for (int k = 0; k < 2; k++)
      begin
        old = comparator_raw;
        comparator_raw = ~comparator_raw;
        tick(5);
        flg = evt(md, old, comparator_raw);
        rd(6'h08);
        chk("evt", rd_v, {2'h0, comparator_raw, flg[0], 2'h0, md[1:0]});
        wr(6'h08, {6'h00, md[1:0]});
        rd(6'h08);
        chk("w0_keep", rd_v[4], flg[0]);
        wr(6'h08, {6'h04, md[1:0]});
        rd(6'h08);
        chk("w1_clear", rd_v[4], 1'b0);
      end
    end
    wr(6'h08, 8'h00);
    wr(6'h08, 8'h08);
    comparator_raw = 1'b1;
    tick(5);
    chk("irq_gie_off", irq_req, 1'b0);
    global_irq_enable = 1'b1;
    tick(3);
    chk("irq_on", irq_req, 1'b1);
    for (int t = 0; t < 20 && irq_req; t++)
      tick(1);
    rd(6'h08);
    chk("ack_clear", rd_v, 8'h28);
    wr(6'h08, 8'h00);
    comparator_raw = 1'b0;
    tick(5);
    chk("irq_ien_off", irq_req, 1'b0);
    wr(6'h08, 8'hC4);
    chk("disable", comparator_disable, 1'b1);
    chk("bandgap", bandgap_select, 1'b1);
    comparator_raw = 1'b1;
    tick(5);
    // Software is taken to have set the timer capture interrupt enable.
    chk("capture_on", capture_out, 1'b1);
    wr(6'h08, 8'h00);
    chk("capture_off", capture_out, 1'b0);
    chk("enable_back", {comparator_disable, bandgap_select}, 8'h00);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
